/* File: pkg/rpt_pkg.sv */
// Functional notes
// - Code 00, card absent: manual, inputs high-impedance
// - Code 01: 12 ms probes, 600 ms limit
// - Code 10 default: 12 ms probes until found
// - Code 11: manual, inputs held at 50 ohm
// - Card present high: power-down, inputs open, drivers off
// - Card present high 5 us, then low: restart
// - Override plus value toggle restarts detection in SMBus slave mode
// - Idle threshold pin levels encode to two-bit field
// - Mode input: pin, SMBus slave, or EEPROM master
// - Pin mode: per-side levels, swing follows emphasis
// - Pin mode rate: Gen 1/2, automatic, Gen 3
// - Register mode: per-lane swing, equalizer, emphasis, termination
// - Register mode: registers drive lanes; pins become straps
// - Rate, detect, threshold pins stand until overridden
// - Registers reset to defaults at power-up, pin mode
// - Card present in register mode keeps register contents
// - Equalizer takes 8 bits; pins reach 16 values
// - Open or low straps give address byte B0
// - Slave address is 58 hex plus strap value
// - Write: address, index, data byte, each acknowledged low
// - Read: index, repeated start, one byte, host not-acknowledges
`default_nettype none
package rpt_pkg;

  typedef enum logic [1:0] {MD_PIN, MD_SLAVE, MD_MASTER} rpt_mode_e;

  localparam int unsigned LANES = 8;

  // Four-level pin codes
  localparam logic [1:0] LV_LOW = 2'h0;
  localparam logic [1:0] LV_RES = 2'h1;
  localparam logic [1:0] LV_FLOAT = 2'h2;
  localparam logic [1:0] LV_HIGH = 2'h3;

  // Detect selection codes
  localparam logic [1:0] SEL_MAN_HIZ = 2'h0;
  localparam logic [1:0] SEL_AUTO_LIM = 2'h1;
  localparam logic [1:0] SEL_AUTO = 2'h2;
  localparam logic [1:0] SEL_MAN_50 = 2'h3;

  // Rate behaviour codes
  localparam logic [1:0] RATE_GEN12 = 2'h0;
  localparam logic [1:0] RATE_AUTO = 2'h1;
  localparam logic [1:0] RATE_GEN3 = 2'h2;

  // Register indexes; byte address is four times the index
  localparam logic [7:0] REG_PWDN = 8'h01;
  localparam logic [7:0] REG_DET = 8'h02;
  localparam logic [7:0] REG_OVR = 8'h03;
  localparam logic [7:0] REG_CFG = 8'h04;
  localparam logic [7:0] REG_STAT = 8'h05;
  localparam logic [7:0] REG_EQ0 = 8'h10;
  localparam logic [7:0] REG_LANE0 = 8'h18;

  // Field positions
  localparam int DET_OVR_BIT = 7;
  localparam int DET_VAL_BIT = 6;
  localparam logic [7:0] DET_MASK = 8'hC0;
  localparam int OVR_RATE_BIT = 0;
  localparam int OVR_RX_DETECT_SELECT_BIT = 1;
  localparam int OVR_THR_BIT = 2;
  localparam int CFG_RATE_LSB = 0;
  localparam int CFG_RX_DETECT_SELECT_LSB = 2;
  localparam int CFG_THR_LSB = 4;
  localparam int LANE_SWING_LSB = 0;
  localparam int LANE_EMPH_LSB = 4;
  localparam int LANE_TDIS_BIT = 7;

  // Reset values
  localparam logic [7:0] PWDN_RST = 8'h00;
  localparam logic [7:0] DET_RST = 8'h00;
  localparam logic [7:0] OVR_RST = 8'h00;
  localparam logic [7:0] CFG_RST = 8'h00;
  localparam logic [7:0] EQ_RST = 8'h00;
  localparam logic [7:0] LANE_RST = 8'h00;

  localparam logic [6:0] SMB_BASE = 7'h58;

  // Pin level tables, entry 0 in the low bits
  localparam logic [127:0] EQ_TABLE = 128'hFFBF7FAA3F2F1F550F0B150703020100;
  localparam logic [47:0] SWING_TABLE = {3'h5, 3'h5, 3'h5, 3'h5, 3'h4,
    3'h4, 3'h4, 3'h3, 3'h3, 3'h3, 3'h2, 3'h2, 3'h2, 3'h1, 3'h1, 3'h0};
  localparam logic [31:0] EMPH_TABLE = {2'h3, 2'h2, 2'h1, 2'h0, 2'h2,
    2'h1, 2'h0, 2'h2, 2'h1, 2'h0, 2'h2, 2'h1, 2'h0, 2'h1, 2'h0, 2'h0};

  // Timing
  localparam int unsigned CLK_KHZ = 100000;
  localparam int unsigned PROBE_MS = 12;
  localparam int unsigned LIMIT_MS = 600;
  localparam int unsigned RESTART_US = 5;
  localparam int unsigned PROBE_CYCLES = PROBE_MS * CLK_KHZ;
  localparam int unsigned LIMIT_CYCLES = LIMIT_MS * CLK_KHZ;
  localparam int unsigned RESTART_CYCLES =
    (RESTART_US * CLK_KHZ + 999) / 1000;

endpackage
`default_nettype wire

/* File: logic/rpt_smb_slave.sv */
`timescale 1ns/100ps
`default_nettype none
module rpt_smb_slave (
  input wire logic clk_i, // System clock
  input wire logic rst_i, // Sync reset
  input wire logic en_i, // Slave enabled
  input wire logic [6:0] addr_i, // Own 7-bit address
  input wire logic scl_i, // Synchronised SCL
  input wire logic sda_i, // Synchronised SDA
  input wire logic [7:0] rd_data_i, // Data at idx_o
  output logic [7:0] idx_o, // Register index
  output logic wr_o, // Write pulse
  output logic [7:0] wr_data_o, // Write data
  output logic sda_oe_o // Pull SDA low
);

  typedef enum logic [2:0] {SM_IDLE, SM_ADDR, SM_REG, SM_WDAT, SM_RDAT}
    rpt_smb_e;

  rpt_smb_e state_q;
  logic scl_q, sda_q, ack_q;
  logic [3:0] bit_q;
  logic [7:0] sh_q, tx_q;
  logic rise, fall, start, stop;
  logic [7:0] byte_in;

  assign rise = scl_i & ~scl_q;
  assign fall = ~scl_i & scl_q;
  assign start = scl_i & scl_q & sda_q & ~sda_i;
  assign stop = scl_i & scl_q & ~sda_q & sda_i;
  assign byte_in = {sh_q[6:0], sda_i};

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end
    else
    begin
      scl_q <= scl_i;
      sda_q <= sda_i;
    end
  end

  always_ff @(posedge clk_i)
  begin
    wr_o <= 1'b0;
    if (rst_i)
    begin
      state_q <= SM_IDLE;
      bit_q <= 4'h0;
      sh_q <= 8'h00;
      tx_q <= 8'h00;
      ack_q <= 1'b0;
      idx_o <= 8'h00;
      wr_data_o <= 8'h00;
    end
    else if (!en_i || stop)
    begin
      state_q <= SM_IDLE;
      ack_q <= 1'b0;
    end
    else if (start)
    begin
      state_q <= SM_ADDR;
      bit_q <= 4'h0;
      ack_q <= 1'b0;
    end
    else if (rise && state_q != SM_IDLE)
    begin
      if (bit_q == 4'h8)
      begin
        bit_q <= 4'h0;
        ack_q <= 1'b0;
        if (state_q == SM_RDAT && !ack_q)
        begin
          if (sda_i)
            state_q <= SM_IDLE;
          else
            tx_q <= rd_data_i;
        end
      end
      else
      begin
        bit_q <= bit_q + 4'h1;
        sh_q <= byte_in;
        if (state_q == SM_RDAT)
          tx_q <= {tx_q[6:0], 1'b0};
        if (bit_q == 4'h7)
        begin
          case (state_q)
            SM_ADDR:
            begin
              if (byte_in[7:1] == addr_i)
              begin
                ack_q <= 1'b1;
                state_q <= byte_in[0] ? SM_RDAT : SM_REG;
                if (byte_in[0])
                  tx_q <= rd_data_i;
              end
              else
                state_q <= SM_IDLE;
            end
            SM_REG:
            begin
              idx_o <= byte_in;
              ack_q <= 1'b1;
              state_q <= SM_WDAT;
            end
            SM_WDAT:
            begin
              wr_o <= 1'b1;
              wr_data_o <= byte_in;
              ack_q <= 1'b1;
            end
            default:
              ack_q <= 1'b0;
          endcase
        end
      end
    end
  end

  // SDA changes after SCL has fallen; start, stop, reset or disable release it at once
  always_ff @(posedge clk_i)
  begin
    if (rst_i || !en_i || start || stop)
      sda_oe_o <= 1'b0;
    else if (fall)
    begin
      if (bit_q == 4'h8)
        sda_oe_o <= ack_q;
      else if (state_q == SM_RDAT)
        sda_oe_o <= ~tx_q[7];
      else
        sda_oe_o <= 1'b0;
    end
  end

endmodule
`default_nettype wire

/* File: logic/rpt_ctrl.sv */
`timescale 1ns/100ps
`default_nettype none
module rpt_ctrl #(
  parameter int unsigned LANES = rpt_pkg::LANES,
  parameter int unsigned PROBE_CYC = rpt_pkg::PROBE_CYCLES,
  parameter int unsigned LIMIT_CYC = rpt_pkg::LIMIT_CYCLES
) (
  input wire logic clk_i, // System clock
  input wire logic rst_i, // Sync reset
  input wire logic wb_cyc_i, // Bus cycle
  input wire logic wb_stb_i, // Bus strobe
  input wire logic wb_we_i, // Write enable
  input wire logic [9:0] wb_adr_i, // Byte address
  input wire logic [3:0] wb_sel_i, // Byte selects
  input wire logic [31:0] wb_dat_i, // Write data
  output logic [31:0] wb_dat_o, // Read data
  output logic wb_ack_o, // Acknowledge
  input wire logic card_present_input_i, // Card present pin
  input wire logic [1:0] rx_detect_select_i, // Level code
  input wire logic [1:0] idle_threshold_select_i, // Level code
  input wire logic [1:0] mgmt_mode_select_i, // Level code
  input wire logic [1:0] rate_select_i, // Level code
  input wire logic [7:0] equalizer_level_pins_i, // A0 A1 B0 B1
  input wire logic [7:0] emphasis_level_pins_i, // A0 A1 B0 B1
  input wire logic [LANES-1:0] rx_sense_i, // Receiver sensed
  input wire logic smb_scl_i, // SMBus clock pin
  input wire logic smb_sda_i, // SMBus data pin
  output logic smb_sda_o, // SDA level when driven
  output logic smb_sda_oe_o, // SDA driven low
  output logic [LANES*8-1:0] eq_setting_o, // Per-lane equalizer
  output logic [LANES*3-1:0] output_swing_o, // Per-lane swing
  output logic [LANES*2-1:0] emphasis_o, // Per-lane emphasis
  output logic [LANES-1:0] term_50_o, // 50 ohm termination
  output logic [LANES-1:0] drv_en_o, // Output driver on
  output logic [1:0] rate_mode_o, // Rate behaviour
  output logic [1:0] idle_thr_o, // Idle threshold field
  output logic [1:0] mode_o, // Operating mode
  output logic powerdown_o, // Power-down
  output logic probe_o, // Receiver probe pulse
  output logic rx_found_o // Receiver detected
);

  typedef enum logic [2:0] {DS_HIZ, DS_PROBE, DS_FOUND, DS_STOP, DS_FIXED}
    rpt_det_e;

  localparam int SW = 27 + LANES;

  ////////////////////////////////////////////////////////////////////////
  // Pin synchronisers

  logic [SW-1:0] pin_raw, meta_q, pin_q;
  logic card_present_input_s, scl_s, sda_s;
  logic [1:0] rxsel_pin, thr_pin, mode_pin, rate_pin;
  logic [7:0] eq_pin, em_pin;
  logic [LANES-1:0] sense_s;

  assign pin_raw = {card_present_input_i, rx_detect_select_i,
    idle_threshold_select_i, mgmt_mode_select_i, rate_select_i,
    equalizer_level_pins_i, emphasis_level_pins_i, rx_sense_i,
    smb_scl_i, smb_sda_i};
  assign {card_present_input_s, rxsel_pin, thr_pin, mode_pin, rate_pin, eq_pin, em_pin,
    sense_s, scl_s, sda_s} = pin_q;

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      meta_q <= SW'(2'h3);
      pin_q <= SW'(2'h3);
    end
    else
    begin
      meta_q <= pin_raw;
      pin_q <= meta_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Mode and register file

  rpt_pkg::rpt_mode_e mode;
  logic regs_clr, reg_mode;
  logic wb_req, wb_wr, smb_wr, wr_en;
  logic [7:0] wr_idx, wr_dat, smb_idx, smb_wdat, smb_rdat, stat;
  logic [7:0] pwdn_q, det_q, ovr_q, cfg_q;
  logic [7:0] eq_q [LANES];
  logic [7:0] lane_q [LANES];

  always_comb
  begin
    case (mode_pin)
      rpt_pkg::LV_HIGH: mode = rpt_pkg::MD_SLAVE;
      rpt_pkg::LV_FLOAT: mode = rpt_pkg::MD_MASTER;
      default: mode = rpt_pkg::MD_PIN;
    endcase
  end

  // Card present never clears registers
  assign regs_clr = rst_i | (mode == rpt_pkg::MD_PIN);
  assign reg_mode = (mode != rpt_pkg::MD_PIN);

  assign wb_req = wb_cyc_i & wb_stb_i;
  assign wb_wr = wb_req & wb_we_i & wb_ack_o & wb_sel_i[0];
  assign wr_en = wb_wr | smb_wr;
  assign wr_idx = wb_wr ? wb_adr_i[9:2] : smb_idx;
  assign wr_dat = wb_wr ? wb_dat_i[7:0] : smb_wdat;

  always_ff @(posedge clk_i)
  begin
    if (regs_clr)
    begin
      pwdn_q <= rpt_pkg::PWDN_RST;
      det_q <= rpt_pkg::DET_RST;
      ovr_q <= rpt_pkg::OVR_RST;
      cfg_q <= rpt_pkg::CFG_RST;
    end
    else if (wr_en)
    begin
      case (wr_idx)
        rpt_pkg::REG_PWDN: pwdn_q <= wr_dat;
        rpt_pkg::REG_DET: det_q <= wr_dat & rpt_pkg::DET_MASK;
        rpt_pkg::REG_OVR: ovr_q <= wr_dat;
        rpt_pkg::REG_CFG: cfg_q <= wr_dat;
        default: pwdn_q <= pwdn_q;
      endcase
    end
  end

  function automatic logic [7:0] reg_rd(input logic [7:0] a);
    logic [7:0] v;
    v = 8'h00;
    case (a)
      rpt_pkg::REG_PWDN: v = pwdn_q;
      rpt_pkg::REG_DET: v = det_q;
      rpt_pkg::REG_OVR: v = ovr_q;
      rpt_pkg::REG_CFG: v = cfg_q;
      rpt_pkg::REG_STAT: v = stat;
      default: v = 8'h00;
    endcase
    for (int k = 0; k < LANES; k++)
    begin
      if (a == rpt_pkg::REG_EQ0 + 8'(k))
        v = eq_q[k];
      if (a == rpt_pkg::REG_LANE0 + 8'(k))
        v = lane_q[k];
    end
    return v;
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Wishbone slave: ack one cycle after the request, unmapped reads zero

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      wb_ack_o <= 1'b0;
    else
      wb_ack_o <= wb_req & ~wb_ack_o;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      wb_dat_o <= 32'h0000_0000;
    else if (wb_req && !wb_ack_o)
      wb_dat_o <= {24'h00_0000, reg_rd(wb_adr_i[9:2])};
  end

  ////////////////////////////////////////////////////////////////////////
  // SMBus slave

  logic [3:0] strap;
  logic [6:0] smb_addr;

  // Straps have pull-downs: only a high level reads as one
  for (genvar k = 0; k < 4; k++)
  begin : g_strap
    assign strap[k] = (eq_pin[2*k +: 2] == rpt_pkg::LV_HIGH);
  end

  assign smb_addr = 7'(rpt_pkg::SMB_BASE + {3'h0, strap});
  always_comb smb_rdat = reg_rd(smb_idx);

  rpt_smb_slave u_smb (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .en_i(mode == rpt_pkg::MD_SLAVE),
    .addr_i(smb_addr),
    .scl_i(scl_s),
    .sda_i(sda_s),
    .rd_data_i(smb_rdat),
    .idx_o(smb_idx),
    .wr_o(smb_wr),
    .wr_data_o(smb_wdat),
    .sda_oe_o(smb_sda_oe_o)
  );

  always_ff @(posedge clk_i)
  begin
    smb_sda_o <= 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////
  // Effective pin or register settings

  logic [1:0] rxsel, rate_d, thr_d, rate_pin_map, thr_pin_map;

  always_comb
  begin
    case (rate_pin)
      rpt_pkg::LV_LOW: rate_pin_map = rpt_pkg::RATE_GEN12;
      rpt_pkg::LV_HIGH: rate_pin_map = rpt_pkg::RATE_GEN3;
      default: rate_pin_map = rpt_pkg::RATE_AUTO;
    endcase
  end

  assign thr_pin_map = {thr_pin == rpt_pkg::LV_LOW ||
    thr_pin == rpt_pkg::LV_HIGH, thr_pin == rpt_pkg::LV_RES ||
    thr_pin == rpt_pkg::LV_HIGH};

  assign rxsel = ovr_q[rpt_pkg::OVR_RX_DETECT_SELECT_BIT] ?
    cfg_q[rpt_pkg::CFG_RX_DETECT_SELECT_LSB +: 2] : rxsel_pin;
  assign rate_d = ovr_q[rpt_pkg::OVR_RATE_BIT] ?
    cfg_q[rpt_pkg::CFG_RATE_LSB +: 2] : rate_pin_map;
  assign thr_d = ovr_q[rpt_pkg::OVR_THR_BIT] ?
    cfg_q[rpt_pkg::CFG_THR_LSB +: 2] : thr_pin_map;

  ////////////////////////////////////////////////////////////////////////
  // Card present, power-down and detect restart

  logic sw_ovr, card_present_input, card_present_input_q, val_q, start_q, restart;
  logic [1:0] rxsel_q;
  logic [15:0] hi_cnt_q;

  assign sw_ovr = (mode == rpt_pkg::MD_SLAVE) &
    det_q[rpt_pkg::DET_OVR_BIT];
  assign card_present_input = sw_ovr ? det_q[rpt_pkg::DET_VAL_BIT] : card_present_input_s;
  assign restart = start_q | (rxsel != rxsel_q) |
    (card_present_input_q & ~card_present_input & (hi_cnt_q == 16'(rpt_pkg::RESTART_CYCLES))) |
    (sw_ovr & (det_q[rpt_pkg::DET_VAL_BIT] != val_q));

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      start_q <= 1'b1;
      card_present_input_q <= 1'b0;
      val_q <= 1'b0;
      rxsel_q <= rpt_pkg::SEL_MAN_HIZ;
    end
    else
    begin
      start_q <= 1'b0;
      card_present_input_q <= card_present_input;
      val_q <= det_q[rpt_pkg::DET_VAL_BIT];
      rxsel_q <= rxsel;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i || !card_present_input)
      hi_cnt_q <= 16'h0000;
    else if (hi_cnt_q != 16'(rpt_pkg::RESTART_CYCLES))
      hi_cnt_q <= hi_cnt_q + 16'h0001;
  end

  ////////////////////////////////////////////////////////////////////////
  // Receiver detect timers and state machine

  rpt_det_e det_q_st;
  logic [31:0] tick_q, elapsed_q;
  logic probing, probe_tick, term_on;

  assign probing = (det_q_st == DS_PROBE) & ~card_present_input;
  assign probe_tick = probing & (tick_q == 32'(PROBE_CYC - 1));

  always_ff @(posedge clk_i)
  begin
    if (rst_i || restart)
    begin
      tick_q <= 32'h0000_0000;
      elapsed_q <= 32'h0000_0000;
    end
    else if (probing)
    begin
      tick_q <= probe_tick ? 32'h0000_0000 : tick_q + 32'h0000_0001;
      if (elapsed_q < 32'(LIMIT_CYC))
        elapsed_q <= elapsed_q + 32'h0000_0001;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      det_q_st <= DS_HIZ;
    else if (restart)
    begin
      case (rxsel)
        rpt_pkg::SEL_MAN_HIZ: det_q_st <= DS_HIZ;
        rpt_pkg::SEL_MAN_50: det_q_st <= DS_FIXED;
        default: det_q_st <= DS_PROBE;
      endcase
    end
    else
    begin
      case (det_q_st)
        DS_PROBE:
        begin
          if (probe_tick && (|sense_s))
            det_q_st <= DS_FOUND;
          else if (rxsel == rpt_pkg::SEL_AUTO_LIM &&
                   elapsed_q >= 32'(LIMIT_CYC))
            det_q_st <= DS_STOP;
        end
        default: det_q_st <= det_q_st;
      endcase
    end
  end

  assign term_on = ~card_present_input &
    (det_q_st == DS_FOUND || det_q_st == DS_FIXED);

  assign stat = {2'h0, mode, card_present_input_q, det_q_st == DS_STOP,
    det_q_st == DS_PROBE, det_q_st == DS_FOUND};

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      probe_o <= 1'b0;
      powerdown_o <= 1'b0;
      rx_found_o <= 1'b0;
      rate_mode_o <= rpt_pkg::RATE_GEN12;
      idle_thr_o <= 2'h0;
      mode_o <= 2'h0;
    end
    else
    begin
      probe_o <= probe_tick;
      powerdown_o <= card_present_input;
      rx_found_o <= (det_q_st == DS_FOUND);
      rate_mode_o <= rate_d;
      idle_thr_o <= thr_d;
      mode_o <= mode;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Per-lane registers and outputs

  for (genvar i = 0; i < LANES; i++)
  begin : g_lane
    logic [3:0] eq_lvl, em_lvl;
    logic [7:0] eq_set_q;
    logic [2:0] swing_q;
    logic [1:0] emph_q;
    logic term_q, drv_q;

    assign eq_lvl = (i < LANES / 2) ? eq_pin[3:0] : eq_pin[7:4];
    assign em_lvl = (i < LANES / 2) ? em_pin[3:0] : em_pin[7:4];

    always_ff @(posedge clk_i)
    begin
      if (regs_clr)
      begin
        eq_q[i] <= rpt_pkg::EQ_RST;
        lane_q[i] <= rpt_pkg::LANE_RST;
      end
      else if (wr_en)
      begin
        if (wr_idx == rpt_pkg::REG_EQ0 + 8'(i))
          eq_q[i] <= wr_dat;
        if (wr_idx == rpt_pkg::REG_LANE0 + 8'(i))
          lane_q[i] <= wr_dat;
      end
    end

    always_ff @(posedge clk_i)
    begin
      if (rst_i)
      begin
        eq_set_q <= 8'h00;
        swing_q <= 3'h0;
        emph_q <= 2'h0;
        term_q <= 1'b0;
        drv_q <= 1'b0;
      end
      else if (reg_mode)
      begin
        eq_set_q <= eq_q[i];
        swing_q <= lane_q[i][rpt_pkg::LANE_SWING_LSB +: 3];
        emph_q <= lane_q[i][rpt_pkg::LANE_EMPH_LSB +: 2];
        term_q <= term_on & ~lane_q[i][rpt_pkg::LANE_TDIS_BIT];
        drv_q <= ~card_present_input & ~pwdn_q[i];
      end
      else
      begin
        eq_set_q <= rpt_pkg::EQ_TABLE[{eq_lvl, 3'h0} +: 8];
        swing_q <= rpt_pkg::SWING_TABLE[int'(em_lvl) * 3 +: 3];
        emph_q <= rpt_pkg::EMPH_TABLE[{em_lvl, 1'b0} +: 2];
        term_q <= term_on;
        drv_q <= ~card_present_input;
      end
    end

    assign eq_setting_o[i*8 +: 8] = eq_set_q;
    assign output_swing_o[i*3 +: 3] = swing_q;
    assign emphasis_o[i*2 +: 2] = emph_q;
    assign term_50_o[i] = term_q;
    assign drv_en_o[i] = drv_q;
  end

endmodule
`default_nettype wire

/* File: bench/rpt_ctrl_assertions.sv */
`timescale 1ns/100ps
`default_nettype none
module rpt_ctrl_chk #(
  parameter int unsigned LANES = 8
) (
  input wire logic clk_i, // Clock
  input wire logic rst_i, // Reset
  input wire logic wb_cyc_i, // Cycle
  input wire logic wb_stb_i, // Strobe
  input wire logic wb_ack_o, // Ack
  input wire logic [31:0] wb_dat_o, // Read data
  input wire logic [LANES-1:0] term_50_o, // Termination
  input wire logic [LANES-1:0] drv_en_o, // Drivers
  input wire logic [1:0] mode_o, // Mode
  input wire logic powerdown_o, // Power-down
  input wire logic probe_o, // Probe pulse
  input wire logic rx_found_o, // Found
  input wire logic smb_sda_oe_o // SDA pull
);
  default clocking @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  a_ack_follows_req: assert property (
    wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("ack missing");
  a_ack_one_cycle: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack too long");
  a_read_upper_zero: assert property (
    wb_ack_o |-> wb_dat_o[31:8] == 24'h000000)
    else $error("upper read bits set");
  a_pd_all_off: assert property (
    powerdown_o && $past(powerdown_o) |-> !term_50_o && !drv_en_o)
    else $error("power-down leaves lanes on");
  a_pd_no_probe: assert property (powerdown_o |-> !probe_o)
    else $error("probe in power-down");
  a_found_term_on: assert property (
    rx_found_o && $past(rx_found_o) && !powerdown_o &&
    !$past(powerdown_o) && mode_o == 2'h0 |-> &term_50_o)
    else $error("found without termination");
  a_probe_gap: assert property (probe_o |=> !probe_o [*8])
    else $error("probes too close");
  a_sda_pin_mode: assert property (
    mode_o == 2'h0 |-> !smb_sda_oe_o)
    else $error("SDA driven in pin mode");
  c_probe: cover property (probe_o);
  c_found: cover property (rx_found_o && !powerdown_o);
  c_sda_ack: cover property (smb_sda_oe_o);
endmodule
bind rpt_ctrl rpt_ctrl_chk #(.LANES(LANES)) i_chk (.*);
`default_nettype wire

/* File: bench/rpt_smb_host.sv */
`timescale 1ns/100ps
`default_nettype none
module rpt_smb_host (
  input wire logic clk_i, // Bench clock
  input wire logic sda_i, // Resolved data line
  output logic scl_o, // Bus clock, high when idle
  output logic sda_oe_o // Pull data low
);
  initial
  begin
    scl_o = 1'h1;
    sda_oe_o = 1'h0;
  end
  task automatic t(input int n);
    repeat (n) @(posedge clk_i);
  endtask
  // One bit slot of 160 ns, sampled at the end of the high half
  task automatic bit_io(input logic b, output logic r);
    t(4);
    sda_oe_o <= !b;
    t(4);
    scl_o <= 1'h1;
    t(8);
    r = sda_i;
    scl_o <= 1'h0;
  endtask
  task automatic start();
    t(4);
    sda_oe_o <= 1'h0;
    t(4);
    scl_o <= 1'h1;
    t(8);
    sda_oe_o <= 1'h1;
    t(8);
    scl_o <= 1'h0;
  endtask
  task automatic stop();
    t(4);
    sda_oe_o <= 1'h1;
    t(4);
    scl_o <= 1'h1;
    t(8);
    sda_oe_o <= 1'h0;
    t(8);
  endtask
  task automatic xbyte(input logic [7:0] d, input logic a,
    output logic [7:0] q, output logic r);
    for (int i = 7; i >= 0; i--)
      bit_io(d[i], q[i]);
    bit_io(a, r);
  endtask
  task automatic xfer(input logic [6:0] ad, input logic rd,
    input logic [7:0] ix, input logic [7:0] d, output logic [7:0] q,
    output logic nak);
    logic r0, r1, r2, r3;
    start();
    xbyte({ad, 1'h0}, 1'h1, q, r0);
    xbyte(ix, 1'h1, q, r1);
    r2 = 1'h0;
    if (rd)
    begin
      start();
      xbyte({ad, 1'h1}, 1'h1, q, r2);
      xbyte(8'hFF, 1'h1, q, r3);
    end
    else
      xbyte(d, 1'h1, q, r2);
    stop();
    nak = r0 | r1 | r2;
  endtask
endmodule
`default_nettype wire

/* File: bench/tb_top.sv */
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, b) \
  begin \
    compares++; \
    if ((a) !== (b)) \
    begin \
      fails++; \
      $display("BAD %0t got %0h want %0h", $time, a, b); \
    end \
  end
module tb_top;
  typedef struct packed {
    logic [1:0] sel, thr, rt;
    logic pr;
    logic [7:0] eqp, emp, term;
    logic pd;
    logic [1:0] thr_e, rt_e;
    logic [7:0] eq0, eq7;
    logic [2:0] sw0;
    logic [1:0] em0;
  } rpt_row_s;
  rpt_row_s rows [5] = '{
    '{2'h0, 2'h0, 2'h0, 1'h0, 8'hC1, 8'h08, 8'h00, 1'h0, 2'h2, 2'h0,
      8'h01, 8'hAA, 3'h3, 2'h2},
    '{2'h3, 2'h3, 2'h3, 1'h0, 8'h3E, 8'h0F, 8'hFF, 1'h0, 2'h3, 2'h2,
      8'hBF, 8'h03, 3'h5, 2'h3},
    '{2'h2, 2'h2, 2'h1, 1'h0, 8'h5A, 8'h06, 8'hFF, 1'h0, 2'h0, 2'h1,
      8'h2F, 8'h15, 3'h3, 2'h0},
    '{2'h1, 2'h1, 2'h1, 1'h0, 8'h00, 8'h00, 8'hFF, 1'h0, 2'h1, 2'h1,
      8'h00, 8'h00, 3'h0, 2'h0},
    '{2'h1, 2'h1, 2'h0, 1'h1, 8'h00, 8'h00, 8'h00, 1'h1, 2'h1, 2'h0,
      8'h00, 8'h00, 3'h0, 2'h0}};
  logic clk_i = 1'h0;
  logic rst_i = 1'h1;
  logic wb_cyc_i = 1'h0, wb_stb_i = 1'h0, wb_we_i = 1'h0;
  logic [9:0] wb_adr_i = 10'h000;
  logic [3:0] wb_sel_i = 4'hF;
  logic [31:0] wb_dat_i = 32'h0, wb_dat_o;
  logic wb_ack_o, card_present_input_i = 1'h0;
  logic [1:0] rx_detect_select_i = 2'h0, idle_threshold_select_i = 2'h0;
  logic [1:0] mgmt_mode_select_i = 2'h0, rate_select_i = 2'h0;
  logic [7:0] equalizer_level_pins_i = 8'h00, emphasis_level_pins_i = 8'h00;
  logic [7:0] rx_sense_i = 8'hFF, term_50_o, drv_en_o, q;
  logic smb_scl_i, smb_sda_i, smb_sda_o, smb_sda_oe_o, h_oe, nk;
  logic [63:0] eq_setting_o;
  logic [23:0] output_swing_o;
  logic [15:0] emphasis_o;
  logic [1:0] rate_mode_o, idle_thr_o, mode_o;
  logic powerdown_o, probe_o, rx_found_o;
  rpt_row_s r;
  int fails = 0, compares = 0, n;
  // Open-drain data line with pull-up
  assign smb_sda_i = !(h_oe || smb_sda_oe_o);
  always #5 clk_i = !clk_i;
  rpt_ctrl #(.PROBE_CYC(40), .LIMIT_CYC(200)) i_dut (.*);
  rpt_smb_host i_host (.clk_i(clk_i), .sda_i(smb_sda_i),
    .scl_o(smb_scl_i), .sda_oe_o(h_oe));
  task automatic w(input int k);
    repeat (k) @(posedge clk_i);
  endtask
  task automatic wb(input logic we, input logic [7:0] ix,
    input logic [7:0] d, output logic [7:0] r);
    int k;
    k = 0;
    @(posedge clk_i);
    wb_cyc_i <= 1'h1;
    wb_stb_i <= 1'h1;
    wb_we_i <= we;
    wb_adr_i <= {ix, 2'h0};
    wb_dat_i <= {24'h0, d};
    do
      @(posedge clk_i);
    while (wb_ack_o !== 1'h1 && ++k < 20);
    if (k >= 20)
      fails++;
    r = wb_dat_o[7:0];
    wb_cyc_i <= 1'h0;
    wb_stb_i <= 1'h0;
  endtask
  task automatic print_verdict();
    if (fails == 0 && compares > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  initial
  begin
    #200000;
    fails++;
    print_verdict();
  end
  initial
  begin
    w(5);
    rst_i <= 1'h0;
    foreach (rows[i])
    begin
      r = rows[i];
      @(posedge clk_i);
      rx_detect_select_i <= r.sel;
      idle_threshold_select_i <= r.thr;
      rate_select_i <= r.rt;
      card_present_input_i <= r.pr;
      equalizer_level_pins_i <= r.eqp;
      emphasis_level_pins_i <= r.emp;
      w(60);
      `CHK(term_50_o, r.term)
      `CHK({powerdown_o, drv_en_o}, {r.pd, {8{!r.pd}}})
      `CHK(idle_thr_o, r.thr_e)
      `CHK(rate_mode_o, r.rt_e)
      `CHK({eq_setting_o[7:0], eq_setting_o[63:56]}, {r.eq0, r.eq7})
      `CHK({output_swing_o[2:0], emphasis_o[1:0]}, {r.sw0, r.em0})
    end
    rx_sense_i <= 8'h00;
    w(460);
    card_present_input_i <= 1'h0;
    w(10);
    `CHK(term_50_o, 8'h00)
    n = 0;
    repeat (150)
    begin
      @(posedge clk_i);
      n += (probe_o === 1'h1);
    end
    `CHK(n, 3)
    w(100);
    n = 0;
    repeat (200)
    begin
      @(posedge clk_i);
      n += (probe_o === 1'h1);
    end
    rx_sense_i <= 8'hFF;
    w(60);
    `CHK({n, term_50_o}, {32'h0, 8'h00})
    card_present_input_i <= 1'h1;
    w(520);
    card_present_input_i <= 1'h0;
    w(60);
    `CHK({rx_found_o, term_50_o}, 9'h1FF)
    equalizer_level_pins_i <= 8'h55;
    mgmt_mode_select_i <= 2'h3;
    w(10);
    `CHK({mode_o, eq_setting_o[7:0]}, 10'h100)
    wb(1'h0, rpt_pkg::REG_CFG, 8'h00, q);
    `CHK(q, rpt_pkg::CFG_RST)
    i_host.xfer(7'h58, 1'h0, rpt_pkg::REG_EQ0, 8'h9C, q, nk);
    w(5);
    `CHK({nk, eq_setting_o[15:0]}, 17'h0009C)
    i_host.xfer(7'h58, 1'h1, rpt_pkg::REG_EQ0, 8'h00, q, nk);
    `CHK({nk, q}, 9'h09C)
    wb(1'h1, 8'h17, 8'h42, q);
    wb(1'h0, 8'h17, 8'h00, q);
    `CHK({q, eq_setting_o[63:56]}, 16'h4242)
    wb(1'h0, 8'hFF, 8'h00, q);
    `CHK(q, 8'h00)
    equalizer_level_pins_i <= 8'hC3;
    w(10);
    i_host.xfer(7'h58, 1'h0, 8'h11, 8'h77, q, nk);
    `CHK(nk, 1'h1)
    i_host.xfer(7'h61, 1'h0, 8'h11, 8'h5A, q, nk);
    w(5);
    `CHK({nk, eq_setting_o[15:8]}, 9'h05A)
    wb(1'h1, rpt_pkg::REG_CFG, 8'h30, q);
    w(5);
    `CHK(idle_thr_o, 2'h1)
    wb(1'h1, rpt_pkg::REG_OVR, 8'h04, q);
    w(5);
    `CHK(idle_thr_o, 2'h3)
    wb(1'h1, rpt_pkg::REG_DET, 8'h80, q);
    wb(1'h1, rpt_pkg::REG_DET, 8'hC0, q);
    w(4);
    `CHK(term_50_o, 8'h00)
    wb(1'h1, rpt_pkg::REG_DET, 8'h80, q);
    w(60);
    `CHK(term_50_o, 8'hFF)
    wb(1'h1, rpt_pkg::REG_DET, 8'h00, q);
    card_present_input_i <= 1'h1;
    w(20);
    card_present_input_i <= 1'h0;
    w(10);
    `CHK(eq_setting_o[7:0], 8'h9C)
    mgmt_mode_select_i <= 2'h0;
    w(10);
    `CHK({mode_o, idle_thr_o}, 4'h1)
    mgmt_mode_select_i <= 2'h3;
    w(10);
    wb(1'h0, rpt_pkg::REG_EQ0, 8'h00, q);
    `CHK(q, rpt_pkg::EQ_RST)
    mgmt_mode_select_i <= 2'h2;
    w(10);
    i_host.xfer(7'h61, 1'h0, 8'h11, 8'h33, q, nk);
    `CHK({mode_o, nk, smb_sda_o}, 4'hA)
    print_verdict();
  end
endmodule
`default_nettype wire
